//--- src/pmam_core.sv
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module pmam_core #(
  parameter int US_CYCLES = pmam_pkg::TICK_CYCLES
) (
  input wire logic core_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire pmam_pkg::pmam_apb_req_t apb_req, // APB request
  output pmam_pkg::pmam_apb_rsp_t apb_rsp, // APB response
  input wire logic [15:0] adc_raw, // Modulator sample, two's complement
  input wire logic trim_good, // Trim memory health
  output logic [1:0] conv_channel, // Channel on the input mux
  output logic conv_busy, // Converter running
  output logic alert_o, // Open-drain alert level
  output logic alert_oe // Alert driven low when high
);

  localparam int TW = (US_CYCLES > 1) ? $clog2(US_CYCLES) : 1;

  // Refuse a timebase that cannot count
  if (US_CYCLES < 1) begin : g_bad_tick
    $error("US_CYCLES must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    pmam_pkg::pmam_seq_t seq;
    logic [1:0] ch;
    logic [TW-1:0] tick_cnt;
    logic [12:0] ticks;
    logic [27:0] acc;
    logic [15:0] res;
    logic [9:0] round;
    logic [2:0][25:0] sum;
    logic [2:0][15:0] sngl;
    logic [3:0][15:0] outv;
    logic [3:0][15:0] cmp;
    logic [3:0] cmp_ok;
    pmam_pkg::pmam_cfg_t cfg;
    logic [3:0] ctl;
    logic [5:0][15:0] thr;
    logic [5:0] flags;
    logic done;
    logic ovf;
    logic trim_ok;
    logic hold;
    logic alert_oe;
    logic soft_rst;
  } pmam_state_t;

  pmam_state_t r;
  pmam_state_t n;

  // Default contents after either reset
  function automatic pmam_state_t rst_state();
    pmam_state_t s;
    s = '0;
    s.seq = pmam_pkg::PMAM_IDLE;
    s.cfg = pmam_pkg::CFG_RESET;
    s.thr = pmam_pkg::THR_RESET;
    return s;
  endfunction

  // Merge write data by byte strobes
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        m[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return m;
  endfunction

  // Scaled power with saturation, top bit flags overflow
  function automatic logic [16:0] pwr_calc(input logic [15:0] a,
                                           input logic [15:0] b);
    logic signed [31:0] p;
    logic signed [31:0] s;
    p = $signed(a) * $signed(b);
    s = p >>> pmam_pkg::PWR_SHIFT;
    if (s[31:15] != {17{s[31]}}) begin
      return {1'b1, s[31] ? 16'h8000 : 16'h7fff};
    end
    return {1'b0, s[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic acc_phase;
  logic wr;
  logic rd;
  logic hit_thr;
  logic hit_res;
  logic mapped;
  logic [2:0] thr_idx;
  logic [1:0] res_idx;
  logic cfg_wr;
  logic diag_rd;
  pmam_pkg::pmam_cfg_t cfg_new;

  assign acc_phase = apb_req.psel && apb_req.penable;
  assign wr = acc_phase && apb_req.pwrite;
  assign rd = acc_phase && !apb_req.pwrite;
  assign hit_thr = apb_req.paddr >= pmam_pkg::OFS_THR &&
                   apb_req.paddr <= pmam_pkg::OFS_THR_LAST &&
                   apb_req.paddr[1:0] == 2'h0;
  assign hit_res = apb_req.paddr >= pmam_pkg::OFS_RES &&
                   apb_req.paddr <= pmam_pkg::OFS_RES_LAST &&
                   apb_req.paddr[1:0] == 2'h0;
  assign mapped = hit_thr || hit_res ||
                  apb_req.paddr == pmam_pkg::OFS_GEN ||
                  apb_req.paddr == pmam_pkg::OFS_CFG ||
                  apb_req.paddr == pmam_pkg::OFS_DIAG;
  assign thr_idx = 3'((apb_req.paddr - pmam_pkg::OFS_THR) >> 2);
  assign res_idx = 2'((apb_req.paddr - pmam_pkg::OFS_RES) >> 2);
  assign cfg_wr = wr && apb_req.paddr == pmam_pkg::OFS_CFG;
  assign diag_rd = rd && apb_req.paddr == pmam_pkg::OFS_DIAG;
  assign cfg_new = pmam_pkg::pmam_cfg_t'(wmerge(r.cfg, apb_req.pwdata,
                                                apb_req.pstrb));

  // Zero-wait answer, error on unmapped addresses
  always_comb begin
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = acc_phase && !mapped;
    apb_rsp.prdata = 32'h0000_0000;
    if (apb_req.paddr == pmam_pkg::OFS_CFG) begin
      apb_rsp.prdata = r.cfg;
    end else if (apb_req.paddr == pmam_pkg::OFS_DIAG) begin
      apb_rsp.prdata[pmam_pkg::DIAG_POL:pmam_pkg::DIAG_HOLD] = r.ctl;
      apb_rsp.prdata[pmam_pkg::DIAG_DONE] = r.done;
      apb_rsp.prdata[pmam_pkg::DIAG_OVF] = r.ovf;
      apb_rsp.prdata[pmam_pkg::DIAG_TRIM] = r.trim_ok;
      apb_rsp.prdata[pmam_pkg::DIAG_FLAGS +: 6] = r.flags;
    end else if (hit_thr) begin
      apb_rsp.prdata[15:0] = r.thr[thr_idx];
    end else if (hit_res) begin
      apb_rsp.prdata[15:0] = r.outv[res_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer helpers
  logic tick;
  logic [2:0] ct_code;
  logic [12:0] period;
  logic [3:0] win_k;
  logic [12:0] win_start;
  logic [1:0] first_ch;
  logic [1:0] nxt_ch;
  logic nxt_found;
  logic load_now;
  logic [3:0] ash;
  logic [9:0] round_last;
  logic fault;
  logic active;
  logic [5:0] flag_now;

  assign tick = r.tick_cnt == TW'(US_CYCLES - 1);
  assign ct_code = (r.ch == 2'h0) ? r.cfg.shunt_ct :
                   (r.ch == 2'h1) ? r.cfg.bus_ct : r.cfg.temp_ct;
  assign period = pmam_pkg::ct_us(ct_code);
  assign win_k = pmam_pkg::WIN_BASE + {1'b0, ct_code};
  assign win_start = period - (13'h0001 << win_k);
  assign ash = pmam_pkg::avg_shift(r.cfg.avg);
  assign round_last = 10'((11'h001 << ash) - 11'h001);
  assign load_now = !nxt_found && r.round == round_last;

  // Channel order: lowest enabled first
  always_comb begin
    first_ch = 2'h0;
    nxt_ch = 2'h0;
    nxt_found = 1'b0;
    for (int i = 2; i >= 0; i--) begin
      if (r.cfg.chan_en[i]) begin
        first_ch = 2'(i);
        if (2'(i) > r.ch) begin
          nxt_ch = 2'(i);
          nxt_found = 1'b1;
        end
      end
    end
  end

  // Signed comparisons against thresholds
  for (genvar f = 0; f < 6; f++) begin : g_cmp
    localparam int SRC = (f < 2) ? 0 : (f < 4) ? 1 : (f == 4) ? 2 : 3;
    localparam bit OVER = (f == 1) || (f == 2) || (f == 4) || (f == 5);
    if (OVER) begin : g_over
      assign flag_now[f] = r.cmp_ok[SRC] &&
        $signed(r.cmp[SRC]) > $signed(r.thr[f]);
    end else begin : g_under
      assign flag_now[f] = r.cmp_ok[SRC] &&
        $signed(r.cmp[SRC]) < $signed(r.thr[f]);
    end
  end

  // Alert source selection
  assign fault = |r.flags;
  assign active = (r.ctl[pmam_pkg::DIAG_HOLD] ? (r.hold || fault) : fault) ||
                  (r.ctl[pmam_pkg::DIAG_DONE_EN] && r.done);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [25:0] s_new;
    logic [25:0] s_sh;
    logic [27:0] a_sh;
    logic [16:0] pw;
    logic done_set;
    logic done_clr;
    logic ovf_set;
    s_new = '0;
    s_sh = '0;
    a_sh = '0;
    pw = '0;
    done_set = 1'b0;
    ovf_set = 1'b0;
    // Mode code 3 acts as shutdown, so it keeps the flag as well
    done_clr = diag_rd || (cfg_wr && (cfg_new.op == pmam_pkg::OP_TRIG ||
               cfg_new.op == pmam_pkg::OP_CONT));
    n = r;
    n.tick_cnt = tick ? '0 : r.tick_cnt + TW'(1);
    n.trim_ok = trim_good;
    n.flags = flag_now;
    // Register writes, honoured in every mode
    if (wr) begin
      if (apb_req.paddr == pmam_pkg::OFS_GEN) begin
        n.soft_rst = apb_req.pstrb[0] && apb_req.pwdata[pmam_pkg::GEN_RST];
      end
      if (apb_req.paddr == pmam_pkg::OFS_DIAG && apb_req.pstrb[0]) begin
        n.ctl = apb_req.pwdata[pmam_pkg::DIAG_POL:pmam_pkg::DIAG_HOLD];
      end
      if (hit_thr) begin
        n.thr[thr_idx] = 16'(wmerge({16'h0000, r.thr[thr_idx]},
                                    apb_req.pwdata, apb_req.pstrb));
      end
      if (cfg_wr) begin
        n.cfg = cfg_new;
      end
    end
    case (r.seq)
      pmam_pkg::PMAM_IDLE: begin
        if (r.cfg.op == pmam_pkg::OP_CONT && |r.cfg.chan_en) begin
          n.seq = pmam_pkg::PMAM_CONV;
          n.ch = first_ch;
        end
      end
      pmam_pkg::PMAM_CONV: begin
        if (tick) begin
          if (r.ticks >= win_start) begin
            n.acc = r.acc + {{12{adc_raw[15]}}, adc_raw};
          end
          n.ticks = r.ticks + 13'h0001;
          if (r.ticks == period - 13'h0001) begin
            a_sh = 28'($signed(n.acc) >>> win_k);
            n.res = a_sh[15:0];
            n.acc = '0;
            n.ticks = '0;
            n.seq = pmam_pkg::PMAM_NEXT;
          end
        end
      end
      pmam_pkg::PMAM_NEXT: begin
        s_new = r.sum[r.ch] + {{10{r.res[15]}}, r.res};
        n.sum[r.ch] = s_new;
        n.sngl[r.ch] = r.res;
        // Single-conversion comparison
        if (!r.ctl[pmam_pkg::DIAG_AVG_CMP]) begin
          n.cmp[r.ch] = r.res;
          n.cmp_ok[r.ch] = 1'b1;
          if (r.ch == 2'h1 && r.cfg.chan_en[0]) begin
            pw = pwr_calc(r.sngl[0], r.res);
            n.cmp[3] = pw[15:0];
            n.cmp_ok[3] = 1'b1;
            ovf_set = pw[16];
          end
        end
        n.seq = pmam_pkg::PMAM_CONV;
        if (nxt_found) begin
          n.ch = nxt_ch;
        end else if (!load_now) begin
          n.round = r.round + 10'h001;
          n.ch = first_ch;
        end else begin
          // Averaging complete: publish results
          for (int c = 0; c < 3; c++) begin
            if (r.cfg.chan_en[c]) begin
              s_sh = 26'($signed(n.sum[c]) >>> ash);
              n.outv[c] = s_sh[15:0];
            end
          end
          if (r.cfg.chan_en[0] && r.cfg.chan_en[1]) begin
            pw = pwr_calc(n.outv[0], n.outv[1]);
            n.outv[3] = pw[15:0];
            ovf_set = pw[16];
          end
          if (r.ctl[pmam_pkg::DIAG_AVG_CMP]) begin
            for (int c = 0; c < 4; c++) begin
              if (r.cfg.chan_en[c % 3] &&
                  (c < 3 || (r.cfg.chan_en[0] && r.cfg.chan_en[1]))) begin
                n.cmp[c] = n.outv[c];
                n.cmp_ok[c] = 1'b1;
              end
            end
          end
          done_set = 1'b1;
          n.sum = '0;
          n.round = '0;
          n.ch = first_ch;
          if (r.cfg.op != pmam_pkg::OP_CONT) begin
            n.seq = pmam_pkg::PMAM_IDLE;
          end
        end
      end
      default: n.seq = pmam_pkg::PMAM_IDLE;
    endcase
    // Mode write aborts; it restarts only in triggered or continuous mode with a channel enabled
    if (cfg_wr) begin
      n.acc = '0;
      n.ticks = '0;
      n.sum = '0;
      n.round = '0;
      n.ch = first_ch;
      n.seq = pmam_pkg::PMAM_IDLE;
      if ((cfg_new.op == pmam_pkg::OP_TRIG ||
           cfg_new.op == pmam_pkg::OP_CONT) && |cfg_new.chan_en) begin
        n.seq = pmam_pkg::PMAM_CONV;
        for (int i = 2; i >= 0; i--) begin
          if (cfg_new.chan_en[i]) begin
            n.ch = 2'(i);
          end
        end
      end
    end
    // Sticky flags: a set in the clearing cycle wins
    n.done = done_set || (r.done && !done_clr);
    n.ovf = ovf_set || (r.ovf && !diag_rd);
    n.hold = r.ctl[pmam_pkg::DIAG_HOLD] &&
             (fault || (r.hold && !diag_rd));
    n.alert_oe = r.ctl[pmam_pkg::DIAG_POL] ? !active : active;
    if (r.soft_rst) begin
      n = rst_state();
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= rst_state();
    end else begin
      r <= n;
    end
  end

  assign conv_channel = r.ch;
  assign conv_busy = r.seq != pmam_pkg::PMAM_IDLE;
  assign alert_o = 1'b0;
  assign alert_oe = r.alert_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_last_result;
    r.seq == pmam_pkg::PMAM_NEXT && load_now && !cfg_wr && !r.soft_rst;
  endsequence

  sequence s_trig_last;
    s_last_result ##0 r.cfg.op == pmam_pkg::OP_TRIG;
  endsequence

  done_sets_a: assert property (s_last_result |=> r.done)
    else $error("done flag not set after averaging");
  done_clears_a: assert property (diag_rd && !r.soft_rst &&
    !(r.seq == pmam_pkg::PMAM_NEXT && load_now) |=> !r.done)
    else $error("done flag survived a diagnostic read");
  trig_returns_a: assert property (s_trig_last |=>
    r.seq == pmam_pkg::PMAM_IDLE [*2])
    else $error("triggered conversion did not return to shutdown");
  shutdown_stays_a: assert property (
    r.seq == pmam_pkg::PMAM_IDLE && r.cfg.op == pmam_pkg::OP_SHUTDOWN &&
    !cfg_wr && !r.soft_rst |=> r.seq == pmam_pkg::PMAM_IDLE)
    else $error("left shutdown without a mode write");
  mode_abort_a: assert property (cfg_wr && !r.soft_rst |=>
    r.ticks == 13'h0000 && r.round == 10'h000)
    else $error("mode write did not restart conversion");
  hold_keeps_a: assert property (r.ctl[pmam_pkg::DIAG_HOLD] &&
    r.hold && !diag_rd && !wr && !r.soft_rst |=>
    r.hold ##1 alert_oe == !$past(r.ctl[pmam_pkg::DIAG_POL]))
    else $error("held alert released without a read");
  alert_pol_a: assert property (!wr && !r.soft_rst |=>
    alert_oe == ($past(active) ^ r.ctl[pmam_pkg::DIAG_POL]))
    else $error("alert drive does not match polarity");
  soft_reset_a: assert property (r.soft_rst |=>
    r.thr == pmam_pkg::THR_RESET && r.cfg == pmam_pkg::CFG_RESET)
    else $error("reset bit did not restore defaults");
  outputs_hold_a: assert property ($changed(r.outv) |->
    $past(r.seq) == pmam_pkg::PMAM_NEXT || $past(r.soft_rst))
    else $error("results changed before averaging completed");
  ready_alert_a: assert property (r.ctl[pmam_pkg::DIAG_DONE_EN] &&
    r.done && !r.ctl[pmam_pkg::DIAG_POL] && !wr && !r.soft_rst |=> alert_oe)
    else $error("done option did not assert alert");

endmodule // pmam_core

//--- src/pmam_pkg.sv
package pmam_pkg;

  // Clock and timebase
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_GEN = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_DIAG = 8'h08;
  localparam logic [7:0] OFS_THR = 8'h0c;
  localparam logic [7:0] OFS_THR_LAST = 8'h20;
  localparam logic [7:0] OFS_RES = 8'h24;
  localparam logic [7:0] OFS_RES_LAST = 8'h30;

  // Mode encodings
  localparam logic [1:0] OP_SHUTDOWN = 2'h0;
  localparam logic [1:0] OP_TRIG = 2'h1;
  localparam logic [1:0] OP_CONT = 2'h2;

  // Threshold reset values, index 0 shunt low .. 5 wattage
  localparam logic [5:0][15:0] THR_RESET = {16'h7fff, 16'hffff, 16'h0000,
                                            16'h7fff, 16'h7fff, 16'h8000};

  // Converter configuration word
  typedef struct packed {
    logic [14:0] rsv;
    logic [2:0] avg;
    logic [2:0] temp_ct;
    logic [2:0] bus_ct;
    logic [2:0] shunt_ct;
    logic [2:0] chan_en;
    logic [1:0] op;
  } pmam_cfg_t;

  localparam pmam_cfg_t CFG_RESET = '{rsv: 15'h0000, avg: 3'h0,
    temp_ct: 3'h5, bus_ct: 3'h5, shunt_ct: 3'h5, chan_en: 3'h7, op: OP_CONT};

  // Diagnostic word layout
  localparam int DIAG_HOLD = 0;
  localparam int DIAG_DONE_EN = 1;
  localparam int DIAG_AVG_CMP = 2;
  localparam int DIAG_POL = 3;
  localparam int DIAG_DONE = 8;
  localparam int DIAG_OVF = 9;
  localparam int DIAG_TRIM = 10;
  localparam int DIAG_FLAGS = 16;
  localparam int GEN_RST = 0;

  // Power scaling and filter window base
  localparam int PWR_SHIFT = 15;
  localparam logic [3:0] WIN_BASE = 4'h5;

  // Sequencer states
  typedef enum logic [1:0] {PMAM_IDLE, PMAM_CONV, PMAM_NEXT} pmam_seq_t;

  // APB carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pmam_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pmam_apb_rsp_t;

  // Conversion time in microseconds per code
  function automatic logic [12:0] ct_us(input logic [2:0] c);
    case (c)
      3'h0: return 13'h0032;
      3'h1: return 13'h0054;
      3'h2: return 13'h0096;
      3'h3: return 13'h0118;
      3'h4: return 13'h021c;
      3'h5: return 13'h041c;
      3'h6: return 13'h081a;
      default: return 13'h1018;
    endcase
  endfunction

  // Averaging count as a power-of-two shift
  function automatic logic [3:0] avg_shift(input logic [2:0] c);
    case (c)
      3'h0: return 4'h0;
      3'h1: return 4'h2;
      3'h2: return 4'h4;
      3'h3: return 4'h6;
      3'h4: return 4'h7;
      3'h5: return 4'h8;
      3'h6: return 4'h9;
      default: return 4'ha;
    endcase
  endfunction

endpackage

//--- tb/pmam_adc_model.sv
`timescale 1ns/1ps
module pmam_adc_model (
  input wire logic core_clk, // System clock
  input wire logic [1:0] conv_channel, // Channel under conversion
  input wire logic conv_busy, // Converter running
  input wire logic [15:0] shunt_v, // Shunt level to present
  input wire logic [15:0] bus_v, // Bus level to present
  input wire logic [15:0] temp_v, // Die level to present
  output logic [15:0] adc_raw, // Modulator sample
  output logic trim_good // Trim memory health
);
  ////////////////////////////////////////////////////////////////////////////
  // Healthy trim memory
  assign trim_good = 1'b1;

  // Sample follows the mux; toggles while idle so stale data never matches
  always_ff @(posedge core_clk) begin
    if (!conv_busy) begin
      adc_raw <= ~adc_raw;
    end else begin
      case (conv_channel)
        2'h0: adc_raw <= shunt_v;
        2'h1: adc_raw <= bus_v;
        default: adc_raw <= temp_v;
      endcase
    end
  end
endmodule // pmam_adc_model

//--- tb/power_monitor_alert_and_modes_test.sv
`timescale 1ns/1ps
module power_monitor_alert_and_modes_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  pmam_pkg::pmam_apb_req_t apb_req = '0;
  pmam_pkg::pmam_apb_rsp_t apb_rsp;
  logic [15:0] adc_raw;
  logic [15:0] shunt_v = 16'h0200;
  logic [15:0] bus_v = 16'h0100;
  logic [15:0] temp_v = 16'h0010;
  logic trim_good, conv_busy, alert_o, alert_oe, e;
  logic [1:0] conv_channel;
  logic [31:0] q;
  int n_mismatch = 0;
  int checks = 0;
  localparam logic [7:0] THR = pmam_pkg::OFS_THR;
  localparam logic [7:0] CFG = pmam_pkg::OFS_CFG;
  localparam logic [7:0] DIAG = pmam_pkg::OFS_DIAG;

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  always #12.5 core_clk = ~core_clk;

  pmam_core #(.US_CYCLES(1)) i_pmam_core (.core_clk(core_clk), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .adc_raw(adc_raw),
    .trim_good(trim_good), .conv_channel(conv_channel),
    .conv_busy(conv_busy), .alert_o(alert_o), .alert_oe(alert_oe));

  pmam_adc_model i_pmam_adc_model (.core_clk(core_clk),
    .conv_channel(conv_channel), .conv_busy(conv_busy), .shunt_v(shunt_v),
    .bus_v(bus_v), .temp_v(temp_v), .adc_raw(adc_raw),
    .trim_good(trim_good));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask

  // One APB transfer: setup, access until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    apb_req.pstrb <= 4'hf;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    // Answer read at the edge, before that edge's updates land
    do begin
      @(posedge core_clk);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, x, q);
  endtask

  // Trigger one conversion and wait for the sequencer to go idle
  task automatic trig();
    int n;
    n = 0;
    wr(CFG, 32'h0000_001d);
    repeat (4) @(posedge core_clk);
    chk("busy start", 32'h1, {31'h0, conv_busy});
    while (conv_busy !== 1'b0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    chk("busy timeout", 32'h0, n / 3000);
  endtask

  task automatic pause();
    repeat (3) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #(25 * 60000);
    n_mismatch++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    pause();
    chk("oe reset", 32'h0, {31'h0, alert_oe});
    chk("alert level", 32'h0, {31'h0, alert_o});
    for (int i = 0; i < 6; i++) begin
      rd("threshold", THR + 8'(4 * i), {16'h0, pmam_pkg::THR_RESET[i]});
    end
    rd("config", CFG, 32'h0000_2dbe);
    apb(1'b0, DIAG, 32'h0);
    chk("trim ok", 32'h1, {31'h0, q[pmam_pkg::DIAG_TRIM]});
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    wr(CFG, 32'h0000_001c);
    wr(THR + 8'h10, 32'h0000_7fff);
    rd("shutdown rw", THR + 8'h10, 32'h0000_7fff);
    wr(THR + 8'h04, 32'h0000_0100);
    repeat (8) @(posedge core_clk);
    chk("stay idle", 32'h0, {31'h0, conv_busy});
    // Over-limit fault through a triggered conversion
    trig();
    apb(1'b0, DIAG, 32'h0);
    chk("done", 32'h1, {31'h0, q[pmam_pkg::DIAG_DONE]});
    chk("over flag", 32'h2, {30'h0, q[17:16]});
    chk("oe fault", 32'h1, {31'h0, alert_oe});
    repeat (8) @(posedge core_clk);
    chk("back idle", 32'h0, {31'h0, conv_busy});
    rd("shunt result", pmam_pkg::OFS_RES, 32'h0000_0200);
    apb(1'b0, DIAG, 32'h0);
    chk("done clr", 32'h0, {31'h0, q[pmam_pkg::DIAG_DONE]});
    wr(DIAG, 32'h1 << pmam_pkg::DIAG_POL);
    pause();
    chk("oe polarity", 32'h0, {31'h0, alert_oe});
    // Held alert outlives the fault until a diagnostic read
    wr(DIAG, 32'h1 << pmam_pkg::DIAG_HOLD);
    shunt_v <= 16'h0050;
    trig();
    pause();
    chk("oe held", 32'h1, {31'h0, alert_oe});
    apb(1'b0, DIAG, 32'h0);
    chk("flag gone", 32'h0, {30'h0, q[17:16]});
    pause();
    chk("oe release", 32'h0, {31'h0, alert_oe});
    // Conversion-ready on the alert pin
    wr(DIAG, 32'h1 << pmam_pkg::DIAG_DONE_EN);
    trig();
    pause();
    chk("oe ready", 32'h1, {31'h0, alert_oe});
    apb(1'b0, DIAG, 32'h0);
    pause();
    chk("oe ready clr", 32'h0, {31'h0, alert_oe});
    // Mode write aborts a running conversion
    wr(CFG, 32'h0000_001d);
    repeat (20) @(posedge core_clk);
    wr(CFG, 32'h0000_001c);
    pause();
    chk("abort", 32'h0, {31'h0, conv_busy});
    rd("no done", DIAG, 32'h1 << pmam_pkg::DIAG_DONE_EN | 32'h400);
    // Under-limit on a negative shunt value
    wr(DIAG, 32'h0);
    wr(THR, 32'h0000_0000);
    shunt_v <= 16'hfff0;
    trig();
    apb(1'b0, DIAG, 32'h0);
    chk("under flag", 32'h1, {30'h0, q[17:16]});
    // Averaged comparison and power overflow over four rounds
    wr(DIAG, 32'h1 << pmam_pkg::DIAG_AVG_CMP);
    shunt_v <= 16'h8000;
    bus_v <= 16'h8000;
    wr(CFG, 32'h0000_401d);
    repeat (300) @(posedge core_clk);
    apb(1'b0, DIAG, 32'h0);
    chk("avg pending", 32'h01, {26'h0, q[21:16]});
    while (conv_busy !== 1'b0) @(posedge core_clk);
    apb(1'b0, DIAG, 32'h0);
    chk("avg flags", 32'h09, {26'h0, q[21:16]});
    chk("overflow", 32'h1, {31'h0, q[pmam_pkg::DIAG_OVF]});
    rd("avg shunt", pmam_pkg::OFS_RES, 32'h0000_8000);
    rd("power sat", pmam_pkg::OFS_RES + 8'h0c, 32'h0000_7fff);
    // Soft reset brings defaults back
    wr(pmam_pkg::OFS_GEN, 32'h1);
    pause();
    rd("soft thr", THR, 32'h0000_8000);
    rd("soft cfg", CFG, 32'h0000_2dbe);
    conclude();
  end
endmodule // power_monitor_alert_and_modes_test
